/* File: include/rvmc_pkg.sv */
// Constants for the regulator voltage-code and buck mode register slice.
// Assumes a serial control engine elsewhere turns host frames into
// single-byte register reads and writes on a simple strobe port.
// How it works
// RULE1: Second LDO bits 7..4 hold its sleep code; reset 1010 or 0000.
// RULE2: Second LDO bits 3..0 hold its normal code; reset 1010 or 0000.
// RULE3: Third LDO bits 7..4 give sleep code while sleep input low; 1011/0000.
// RULE4: Third LDO bits 3..0 hold its normal code; reset 1011 or 0000.
// RULE5: Host keeps third LDO sleep code equal to normal when no change wanted.
// RULE6: Control bit 5 picks third buck auto (0) or forced PWM (1), by option.
// RULE7: Control bit 4 picks second buck auto or forced PWM; resets 0.
// RULE8: Control bit 3 picks first buck auto or forced PWM; resets 0.
// RULE9: Bit 2 low turns third buck off despite pins and force bit; resets 1.
// RULE10: Bit 1 low turns second buck off despite pins and force; resets 1.
// RULE11: Bit 0 low turns first buck off despite pins and force; resets 1.
// RULE12: Second LDO uses sleep code while sleep input low, else normal.
// RULE13: Control bits 7 and 6 read zero and ignore writes.

`default_nettype none

package rvmc_pkg;

	// Register offsets
	localparam logic [7:0] RVMC_OFS_LDO2 = 8'h9A;
	localparam logic [7:0] RVMC_OFS_LDO3 = 8'h9B;
	localparam logic [7:0] RVMC_OFS_CTRL = 8'h9C;

	// Field positions
	localparam int RVMC_SLP_MSB = 7;
	localparam int RVMC_SLP_LSB = 4;
	localparam int RVMC_NRM_MSB = 3;
	localparam int RVMC_NRM_LSB = 0;
	localparam int RVMC_PWM_MSB = 5;
	localparam int RVMC_PWM_LSB = 3;
	localparam int RVMC_OFF_MSB = 2;
	localparam int RVMC_OFF_LSB = 0;

	// Reset values; the standard option, the all-zero LDO option and the forced-PWM third buck option
	localparam logic [3:0] RVMC_RST_LDO2_STD = 4'hA;
	localparam logic [3:0] RVMC_RST_LDO3_STD = 4'hB;
	localparam logic [3:0] RVMC_RST_LDO_ALT  = 4'h0;
	localparam logic [1:0] RVMC_RST_PWM12    = 2'h0;
	localparam logic [0:0] RVMC_RST_PWM3_STD = 1'h0;
	localparam logic [0:0] RVMC_RST_PWM3_ALT = 1'h1;
	localparam logic [2:0] RVMC_RST_OFF_N    = 3'h7;
	localparam logic [7:0] RVMC_RD_NONE      = 8'h00;

endpackage : rvmc_pkg

`default_nettype wire

/* File: hdl/rvmc_code_sel.sv */
// Picks the applied voltage code of one LDO from its sleep and normal codes.
// Assumes the sleep indication is synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none

module rvmc_code_sel #(
	parameter int W = 4
) (
	input  wire logic         i_ref_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_sleep_indication_n,
	input  wire logic [W-1:0] i_sleep_code,
	input  wire logic [W-1:0] i_normal_code,
	output logic      [W-1:0] o_code
);

	// Registered so the regulator never sees a glitch between codes
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_code <= '0;
		end else if (!i_sleep_indication_n) begin
			o_code <= i_sleep_code;
		end else begin
			o_code <= i_normal_code;
		end
	end

endmodule : rvmc_code_sel

`default_nettype wire

/* File: hdl/rvmc_regs.sv */
// Voltage-code and buck mode/disable registers with their applied outputs.
// Assumes a serial engine issues one-cycle read/write strobes with an
// 8-bit register address; all inputs are synchronous to i_ref_clk.
`timescale 1ns/1ps
`default_nettype none

module rvmc_regs (
	input  wire logic       i_ref_clk,
	input  wire logic       i_resetn,
	input  wire logic       i_otp_ldo_zero,
	input  wire logic       i_otp_buck3_pwm,
	input  wire logic [7:0] i_reg_addr,
	input  wire logic       i_reg_wr,
	input  wire logic [7:0] i_reg_wdata,
	input  wire logic       i_reg_rd,
	input  wire logic       i_sleep_indication_n,
	input  wire logic [2:0] i_buck_seq_en,
	input  wire logic [2:0] i_buck_force_on,
	output logic      [7:0] o_reg_rdata,
	output logic            o_reg_rvalid,
	output logic      [3:0] o_ldo_second_code,
	output logic      [3:0] o_ldo_third_code,
	output logic      [2:0] o_buck_pwm_select,
	output logic      [2:0] o_buck_on
);

	////////////////////////////////////////////////////////////////////////
	// Reset release

	logic rst_meta;
	logic rst_n;
	logic init_pending;

	// Two-stage release keeps the deassertion clean on every flop below
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// One cycle after release the factory straps are loaded
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			init_pending <= 1'b1;
		end else begin
			init_pending <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register storage

	logic [7:0] ldo_second_voltage_codes;
	logic [7:0] ldo_third_voltage_codes;
	logic [2:0] buck_pwm_select;
	logic [2:0] buck_off_n;
	logic       wr_ldo2;
	logic       wr_ldo3;
	logic       wr_ctrl;
	logic [3:0] ldo2_rst_code;
	logic [3:0] ldo3_rst_code;
	logic [0:0] pwm3_rst;

	assign wr_ldo2 = i_reg_wr && (i_reg_addr == rvmc_pkg::RVMC_OFS_LDO2);
	assign wr_ldo3 = i_reg_wr && (i_reg_addr == rvmc_pkg::RVMC_OFS_LDO3);
	assign wr_ctrl = i_reg_wr && (i_reg_addr == rvmc_pkg::RVMC_OFS_CTRL);

	// Option-dependent reset values, chosen from the straps
	assign ldo2_rst_code = i_otp_ldo_zero ? rvmc_pkg::RVMC_RST_LDO_ALT
		: rvmc_pkg::RVMC_RST_LDO2_STD;
	assign ldo3_rst_code = i_otp_ldo_zero ? rvmc_pkg::RVMC_RST_LDO_ALT
		: rvmc_pkg::RVMC_RST_LDO3_STD;
	assign pwm3_rst = i_otp_buck3_pwm ? rvmc_pkg::RVMC_RST_PWM3_ALT
		: rvmc_pkg::RVMC_RST_PWM3_STD;

	// Second LDO codes; a write in the strap-load cycle is lost
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ldo_second_voltage_codes <= {rvmc_pkg::RVMC_RST_LDO2_STD,
				rvmc_pkg::RVMC_RST_LDO2_STD};
		end else if (init_pending) begin
			ldo_second_voltage_codes <= {ldo2_rst_code,
				ldo2_rst_code}; // [RULE1] [RULE2]
		end else if (wr_ldo2) begin
			ldo_second_voltage_codes <= i_reg_wdata; // [RULE1] [RULE2]
		end
	end

	// Third LDO codes
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ldo_third_voltage_codes <= {rvmc_pkg::RVMC_RST_LDO3_STD,
				rvmc_pkg::RVMC_RST_LDO3_STD};
		end else if (init_pending) begin
			ldo_third_voltage_codes <= {ldo3_rst_code,
				ldo3_rst_code}; // [RULE3] [RULE4]
		end else if (wr_ldo3) begin
			ldo_third_voltage_codes <= i_reg_wdata; // [RULE3] [RULE4]
		end
	end

	// Buck mode and disable bits; bits 7 and 6 have no storage at all
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			buck_pwm_select <= {rvmc_pkg::RVMC_RST_PWM3_STD,
				rvmc_pkg::RVMC_RST_PWM12};
			buck_off_n      <= rvmc_pkg::RVMC_RST_OFF_N;
		end else if (init_pending) begin
			buck_pwm_select <= {pwm3_rst, rvmc_pkg::RVMC_RST_PWM12}; // [RULE6]
			buck_off_n      <= rvmc_pkg::RVMC_RST_OFF_N; // [RULE9]
		end else if (wr_ctrl) begin
			buck_pwm_select <= i_reg_wdata[rvmc_pkg::RVMC_PWM_MSB:
				rvmc_pkg::RVMC_PWM_LSB]; // [RULE6] [RULE7] [RULE8] [RULE13]
			buck_off_n      <= i_reg_wdata[rvmc_pkg::RVMC_OFF_MSB:
				rvmc_pkg::RVMC_OFF_LSB]; // [RULE9] [RULE10] [RULE11]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port

	// Unmapped addresses read zero so a stray poll is harmless
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_reg_rdata  <= rvmc_pkg::RVMC_RD_NONE;
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_rd;
			if (!i_reg_rd) begin
				o_reg_rdata <= o_reg_rdata;
			end else begin
				case (i_reg_addr)
					rvmc_pkg::RVMC_OFS_LDO2: begin
						o_reg_rdata <= ldo_second_voltage_codes;
					end
					rvmc_pkg::RVMC_OFS_LDO3: begin
						o_reg_rdata <= ldo_third_voltage_codes;
					end
					rvmc_pkg::RVMC_OFS_CTRL: begin
						o_reg_rdata <= {2'h0, buck_pwm_select,
							buck_off_n}; // [RULE13]
					end
					default: begin
						o_reg_rdata <= rvmc_pkg::RVMC_RD_NONE;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Applied regulator controls

	rvmc_code_sel #(
		.W (4)
	) u_ldo_second (
		.i_ref_clk            (i_ref_clk),
		.i_rst_n              (rst_n),
		.i_sleep_indication_n (i_sleep_indication_n),
		.i_sleep_code         (ldo_second_voltage_codes[
			rvmc_pkg::RVMC_SLP_MSB:rvmc_pkg::RVMC_SLP_LSB]), // [RULE12]
		.i_normal_code        (ldo_second_voltage_codes[
			rvmc_pkg::RVMC_NRM_MSB:rvmc_pkg::RVMC_NRM_LSB]),
		.o_code               (o_ldo_second_code)
	);

	rvmc_code_sel #(
		.W (4)
	) u_ldo_third (
		.i_ref_clk            (i_ref_clk),
		.i_rst_n              (rst_n),
		.i_sleep_indication_n (i_sleep_indication_n),
		.i_sleep_code         (ldo_third_voltage_codes[
			rvmc_pkg::RVMC_SLP_MSB:rvmc_pkg::RVMC_SLP_LSB]), // [RULE3]
		.i_normal_code        (ldo_third_voltage_codes[
			rvmc_pkg::RVMC_NRM_MSB:rvmc_pkg::RVMC_NRM_LSB]),
		.o_code               (o_ldo_third_code)
	);

	// Disable overrides both sequencer pins and the force-on bits
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_buck_pwm_select <= 3'h0;
			o_buck_on         <= 3'h0;
		end else begin
			o_buck_pwm_select <= buck_pwm_select; // [RULE6] [RULE7] [RULE8]
			o_buck_on <= buck_off_n & (i_buck_seq_en
				| i_buck_force_on); // [RULE9] [RULE10] [RULE11]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions

	sequence s_ctrl_write;
		wr_ctrl && !init_pending;
	endsequence

	sequence s_ctrl_read;
		i_reg_rd && (i_reg_addr == rvmc_pkg::RVMC_OFS_CTRL);
	endsequence

	property p_ldo2_sleep;
		@(posedge i_ref_clk) disable iff (!rst_n)
		!i_sleep_indication_n |=> o_ldo_second_code ==
			$past(ldo_second_voltage_codes[7:4]);
	endproperty
	a_ldo2_sleep: assert property (p_ldo2_sleep) // [RULE1] [RULE12]
		else $error("second LDO sleep code not applied");

	property p_ldo2_normal;
		@(posedge i_ref_clk) disable iff (!rst_n)
		i_sleep_indication_n |=> o_ldo_second_code ==
			$past(ldo_second_voltage_codes[3:0]);
	endproperty
	a_ldo2_normal: assert property (p_ldo2_normal) // [RULE2] [RULE12]
		else $error("second LDO normal code not applied");

	property p_ldo3_sleep;
		@(posedge i_ref_clk) disable iff (!rst_n)
		!i_sleep_indication_n |=> o_ldo_third_code ==
			$past(ldo_third_voltage_codes[7:4]);
	endproperty
	a_ldo3_sleep: assert property (p_ldo3_sleep) // [RULE3]
		else $error("third LDO sleep code not applied");

	property p_ldo3_normal;
		@(posedge i_ref_clk) disable iff (!rst_n)
		i_sleep_indication_n |=> o_ldo_third_code ==
			$past(ldo_third_voltage_codes[3:0]);
	endproperty
	a_ldo3_normal: assert property (p_ldo3_normal) // [RULE4]
		else $error("third LDO normal code not applied");

	property p_ldo_strap;
		@(posedge i_ref_clk) disable iff (!rst_n)
		init_pending |=> ldo_second_voltage_codes ==
			{2{$past(i_otp_ldo_zero) ? rvmc_pkg::RVMC_RST_LDO_ALT
			: rvmc_pkg::RVMC_RST_LDO2_STD}}
			&& ldo_third_voltage_codes ==
			{2{$past(i_otp_ldo_zero) ? rvmc_pkg::RVMC_RST_LDO_ALT
			: rvmc_pkg::RVMC_RST_LDO3_STD}};
	endproperty
	a_ldo_strap: assert property (p_ldo_strap) // [RULE1] [RULE4]
		else $error("LDO reset code does not follow option");

	property p_ctrl_strap;
		@(posedge i_ref_clk) disable iff (!rst_n)
		init_pending |=> buck_off_n == 3'h7 && buck_pwm_select ==
			{$past(i_otp_buck3_pwm), 2'h0};
	endproperty
	a_ctrl_strap: assert property (p_ctrl_strap) // [RULE6] [RULE7] [RULE8]
		else $error("control reset value wrong");

	property p_pwm_follows;
		@(posedge i_ref_clk) disable iff (!rst_n)
		s_ctrl_write |-> ##2 o_buck_pwm_select == $past(i_reg_wdata[5:3], 2);
	endproperty
	a_pwm_follows: assert property (p_pwm_follows) // [RULE6] [RULE7] [RULE8]
		else $error("buck mode output does not follow write");

	property p_buck_off;
		@(posedge i_ref_clk) disable iff (!rst_n)
		s_ctrl_write ##1 (buck_off_n != 3'h7) |=>
			(o_buck_on & ~$past(buck_off_n)) == 3'h0;
	endproperty
	a_buck_off: assert property (p_buck_off) // [RULE9] [RULE10] [RULE11]
		else $error("disabled buck still on");

	property p_buck_on;
		@(posedge i_ref_clk) disable iff (!rst_n)
		1'b1 |=> o_buck_on == ($past(buck_off_n) &
			($past(i_buck_seq_en) | $past(i_buck_force_on)));
	endproperty
	a_buck_on: assert property (p_buck_on) // [RULE9] [RULE10] [RULE11]
		else $error("buck enable combination wrong");

	property p_rsv_zero;
		@(posedge i_ref_clk) disable iff (!rst_n)
		s_ctrl_read |=> o_reg_rvalid && o_reg_rdata[7:6] == 2'h0;
	endproperty
	a_rsv_zero: assert property (p_rsv_zero) // [RULE13]
		else $error("control bits 7..6 not zero");

endmodule : rvmc_regs

`default_nettype wire

/* File: bench/rvmc_host_model.sv */
// Host model: issues single-byte register reads and writes.
// Assumes the register port samples one-cycle strobes on the rising edge.
`timescale 1ns/1ps
`default_nettype none

module rvmc_host_model (
	input  wire logic       i_ref_clk,
	input  wire logic [7:0] i_reg_rdata,
	input  wire logic       i_reg_rvalid,
	output logic      [7:0] o_reg_addr,
	output logic            o_reg_wr,
	output logic      [7:0] o_reg_wdata,
	output logic            o_reg_rd
);

	// Idle bus at time zero
	initial begin
		o_reg_addr  = 8'h00;
		o_reg_wr    = 1'b0;
		o_reg_wdata = 8'h00;
		o_reg_rd    = 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// Write strobe; data is inverted after release so stale data never
	// looks valid
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		o_reg_addr  <= a;
		o_reg_wdata <= d;
		o_reg_wr    <= 1'b1;
		@(posedge i_ref_clk);
		o_reg_wr    <= 1'b0;
		o_reg_wdata <= ~d;
	endtask : wr_reg

	// Read strobe, then a bounded wait for the valid pulse
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d,
		output bit ok);
		ok = 1'b0;
		d  = 8'h00;
		@(posedge i_ref_clk);
		o_reg_addr <= a;
		o_reg_rd   <= 1'b1;
		@(posedge i_ref_clk);
		o_reg_rd   <= 1'b0;
		for (int n = 0; n < 8 && !ok; n++) begin
			@(posedge i_ref_clk);
			if (i_reg_rvalid === 1'b1) begin
				ok = 1'b1;
				d  = i_reg_rdata;
			end
		end
	endtask : rd_reg

	// Both third LDO codes equal: no voltage change on sleep
	task automatic set_ldo3_flat(input logic [3:0] c);
		wr_reg(rvmc_pkg::RVMC_OFS_LDO3, {c, c});
	endtask : set_ldo3_flat

endmodule : rvmc_host_model
`default_nettype wire

/* File: bench/testbench.sv */
// Testbench for the regulator code and buck control register slice.
// Assumes the host model drives the register strobe port.
`timescale 1ns/1ps
`default_nettype none

module testbench;

	logic       ref_clk, resetn, otp_zero, otp_pwm, sleep_n;
	logic       reg_wr, reg_rd, rvalid;
	logic [7:0] addr, wdata, rdata;
	logic [2:0] seq_en, force_on, pwm, on;
	logic [3:0] ldo2, ldo3;
	int         err_total, n_checks;
	logic [7:0] exp_v;

	rvmc_host_model host_u (.i_ref_clk(ref_clk), .i_reg_rdata(rdata),
		.i_reg_rvalid(rvalid), .o_reg_addr(addr), .o_reg_wr(reg_wr),
		.o_reg_wdata(wdata), .o_reg_rd(reg_rd));

	rvmc_regs dut_u (.i_ref_clk(ref_clk), .i_resetn(resetn),
		.i_otp_ldo_zero(otp_zero), .i_otp_buck3_pwm(otp_pwm),
		.i_reg_addr(addr), .i_reg_wr(reg_wr), .i_reg_wdata(wdata),
		.i_reg_rd(reg_rd), .i_sleep_indication_n(sleep_n),
		.i_buck_seq_en(seq_en), .i_buck_force_on(force_on),
		.o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
		.o_ldo_second_code(ldo2), .o_ldo_third_code(ldo3),
		.o_buck_pwm_select(pwm), .o_buck_on(on));

	// 250 MHz clock
	always #2 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// A missing valid pulse ends the run rather than hanging
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		bit         ok;
		host_u.rd_reg(a, d, ok);
		if (!ok) begin
			err_total++;
			$display("mismatch rvalid expected 1 seen 0");
			end_sim();
		end else begin
			chk($sformatf("reg_%h", a), e, d);
		end
	endtask : rd_chk

	// Straps are held across release; accesses wait out the init cycle
	task automatic do_reset(input logic z, input logic p);
		@(posedge ref_clk);
		resetn   <= 1'b0;
		otp_zero <= z;
		otp_pwm  <= p;
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (6) @(posedge ref_clk);
	endtask : do_reset

	task automatic outs(input logic [3:0] l2, input logic [3:0] l3);
		repeat (3) @(posedge ref_clk);
		chk("ldo2_code", {4'h0, l2}, {4'h0, ldo2});
		chk("ldo3_code", {4'h0, l3}, {4'h0, ldo3});
	endtask : outs

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		ref_clk = 1'b0;
		resetn = 1'b0;
		otp_zero = 1'b0;
		otp_pwm = 1'b0;
		sleep_n = 1'b1;
		seq_en = 3'h7;
		force_on = 3'h0;
		err_total = 0;
		n_checks = 0;
		// Every strap pair, each behind a fresh reset; straps are independent
		for (int o = 0; o < 4; o++) begin
			do_reset(o[0], o[1]);
			rd_chk(8'h9A, o[0] ? 8'h00 : 8'hAA);
			rd_chk(8'h9B, o[0] ? 8'h00 : 8'hBB);
			rd_chk(8'h9C, o[1] ? 8'h27 : 8'h07);
			outs(o[0] ? 4'h0 : 4'hA, o[0] ? 4'h0 : 4'hB);
			chk("pwm", {5'h0, o[1], 2'h0}, {5'h0, pwm});
			chk("on", 8'h07, {5'h0, on});
		end
		host_u.wr_reg(8'h9A, 8'h5C);
		host_u.wr_reg(8'h9B, 8'h3E);
		rd_chk(8'h9A, 8'h5C);
		outs(4'hC, 4'hE);
		sleep_n <= 1'b0;
		outs(4'h5, 4'h3);
		host_u.set_ldo3_flat(4'h9);
		outs(4'h5, 4'h9);
		sleep_n <= 1'b1;
		host_u.wr_reg(8'h9C, 8'hFF);
		rd_chk(8'h9C, 8'h3F);
		// Pin and force-on mixes; the last relies on force-on alone, so the
		// disable bit must still win over it
		for (int p = 0; p < 3; p++) begin
			seq_en <= (p == 0) ? 3'h5 : (p == 1) ? 3'h2 : 3'h0;
			force_on <= (p == 0) ? 3'h2 : (p == 1) ? 3'h0 : 3'h4;
			for (int k = 0; k < 8; k++) begin
				host_u.wr_reg(8'h9C, {2'b11, k[2:0], k[2:0]});
				repeat (3) @(posedge ref_clk);
				exp_v = {5'h0, k[2:0]};
				chk("pwm", exp_v, {5'h0, pwm});
				exp_v = {5'h0, k[2:0] & (seq_en | force_on)};
				chk("on", exp_v, {5'h0, on});
			end
		end
		host_u.wr_reg(8'h9D, 8'h00);
		rd_chk(8'h9D, 8'h00);
		rd_chk(8'h9C, 8'h3F);
		end_sim();
	end

endmodule : testbench
`default_nettype wire
